//--- amp_cfg_map.vh
// Purpose: Register map, field positions and reset values for the audio port
//          and modulator configuration block.
// Assumes: Byte-wide registers behind the two-wire control port.
// Notes:   Definitions only.
`ifndef AMP_CFG_MAP_VH
`define AMP_CFG_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MODULATOR_CONFIG_OFS 8'h02
`define AUDIO_INPUT_CONFIG_OFS 8'h03
`define CHANNEL_RUN_SELECT_OFS 8'h04

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MODULATOR_CONFIG_RST 8'h62
`define AUDIO_INPUT_CONFIG_RST 8'h04
`define CHANNEL_RUN_SELECT_RST 8'h55

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MOD_FREQ_HI 6
`define MOD_FREQ_LO 4
`define MOD_OSR_BIT 2
`define MOD_PHASE_HI 1
`define MOD_PHASE_LO 0
`define AIN_RATE_HI 7
`define AIN_RATE_LO 6
`define AIN_GROUP_BIT 5
`define AIN_SLOT16_BIT 4
`define AIN_SWAP_BIT 3
`define AIN_FMT_HI 2
`define AIN_FMT_LO 0

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define FMT_RJ24 3'h0
`define FMT_RJ20 3'h1
`define FMT_RJ18 3'h2
`define FMT_RJ16 3'h3
`define FMT_I2S 3'h4
`define FMT_LJ 3'h5
`define FMT_DSP 3'h6
`define RUN_PLAY 2'h0
`define RUN_FLOAT 2'h1
`define RUN_MUTE 2'h2
`define RUN_DIAG 2'h3

// ----------------------------------------------------------------------
// Control port
// ----------------------------------------------------------------------
`define CTRL_DEV_ADDR 7'h2a
`define SLOT_COUNT 8

`endif

//--- ctrl_port_target.v
// Purpose: Two-wire control port target with auto-incrementing register pointer.
// Assumes: Clock and data pins are asynchronous; ref_clk far faster than the link.
// Notes:   Open-drain data: sda_oe_n low pulls the line low.
`include "amp_cfg_map.vh"

module ctrl_port_target #(
  parameter [6:0] DEV_ADDR = `CTRL_DEV_ADDR
) (
  input wire ref_clk,
  input wire srst,
  input wire scl_in,
  input wire sda_in,
  input wire [7:0] rd_data,
  output reg sda_oe_n,
  output reg wr_stb,
  output reg [7:0] reg_ptr,
  output reg [7:0] wr_data
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX = 5'h02;
  localparam [4:0] ST_ACK = 5'h04;
  localparam [4:0] ST_TX = 5'h08;
  localparam [4:0] ST_RACK = 5'h10;

  reg scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  reg [4:0] state_q;
  reg [7:0] sh_q;
  reg [2:0] cnt_q;
  reg [1:0] idx_q;
  reg rw_q, phase_q, nack_q;
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_c = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_c = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire [7:0] byte_in = {sh_q[6:0], sda_s2};

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_s3 <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_s3 <= sda_s2;
  end

  // ----------------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      phase_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe_n <= 1'b1;
      wr_stb <= 1'b0;
      reg_ptr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_c) begin
        state_q <= ST_RX;
        cnt_q <= 3'h0;
        idx_q <= 2'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        state_q <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (state_q)
          ST_RX: begin
            if (scl_rise) begin
              sh_q <= byte_in;
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                phase_q <= 1'b0;
                state_q <= ST_ACK;
                if (idx_q != 2'h3) begin
                  idx_q <= idx_q + 2'h1;
                end
                if (idx_q == 2'h0) begin
                  rw_q <= sda_s2;
                  // A foreign address is left alone until the next start
                  if (byte_in[7:1] != DEV_ADDR) begin
                    state_q <= ST_IDLE;
                  end
                end else if (idx_q == 2'h1) begin
                  reg_ptr <= byte_in;
                end else begin
                  wr_data <= byte_in;
                  wr_stb <= 1'b1;
                end
              end
            end
            if (wr_stb) begin
              reg_ptr <= reg_ptr + 8'h01;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!phase_q) begin
                phase_q <= 1'b1;
                sda_oe_n <= 1'b0;
              end else if (rw_q) begin
                state_q <= ST_TX;
                sh_q <= rd_data;
                cnt_q <= 3'h0;
                sda_oe_n <= rd_data[7];
              end else begin
                state_q <= ST_RX;
                cnt_q <= 3'h0;
                sda_oe_n <= 1'b1;
              end
            end
            if (wr_stb) begin
              reg_ptr <= reg_ptr + 8'h01;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (cnt_q == 3'h7) begin
                sda_oe_n <= 1'b1;
                state_q <= ST_RACK;
                phase_q <= 1'b0;
                reg_ptr <= reg_ptr + 8'h01;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                sda_oe_n <= sh_q[6];
                cnt_q <= cnt_q + 3'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_s2;
              phase_q <= 1'b1;
            end else if (scl_fall && phase_q) begin
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                state_q <= ST_TX;
                sh_q <= rd_data;
                cnt_q <= 3'h0;
                sda_oe_n <= rd_data[7];
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

//--- audio_port_modulator_config.v
// Purpose: Serial audio port and modulator configuration with slot capture.
// Assumes: Audio clocks come from the host, far slower than ref_clk.
// Notes:   Every frame is treated as up to eight slots; two-channel formats
//          simply fill the first two.
`include "amp_cfg_map.vh"

module audio_port_modulator_config #(
  parameter [6:0] DEV_ADDR = `CTRL_DEV_ADDR,
  parameter SAMPLE_W = 24
) (
  input wire ref_clk,
  input wire srst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output wire sda_oe_n,
  input wire bit_clk_in,
  input wire frame_sync_in,
  input wire serial_data_in,
  output reg [SAMPLE_W-1:0] ch1_sample,
  output reg [SAMPLE_W-1:0] ch2_sample,
  output reg [SAMPLE_W-1:0] ch3_sample,
  output reg [SAMPLE_W-1:0] ch4_sample,
  output reg sample_valid,
  output reg [3:0] ch_output_float,
  output reg [3:0] ch_diag_run,
  output reg [5:0] switch_mult,
  output reg modulator_oversample_select,
  output reg [5:0] phase_offset_deg,
  output reg [1:0] incoming_rate_select
);

  reg [7:0] modulator_config_q, audio_input_config_q, channel_run_select_q;
  wire wr_stb;
  wire [7:0] reg_ptr, wr_data;
  reg [7:0] rd_data;

  // ----------------------------------------------------------------------
  // Control port
  // ----------------------------------------------------------------------
  ctrl_port_target #(.DEV_ADDR(DEV_ADDR)) u_ctrl (
    .ref_clk(ref_clk),
    .srst(srst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .rd_data(rd_data),
    .sda_oe_n(sda_oe_n),
    .wr_stb(wr_stb),
    .reg_ptr(reg_ptr),
    .wr_data(wr_data)
  );

  always @* begin
    if (reg_ptr == `MODULATOR_CONFIG_OFS) begin
      rd_data = modulator_config_q;
    end else if (reg_ptr == `AUDIO_INPUT_CONFIG_OFS) begin
      rd_data = audio_input_config_q;
    end else if (reg_ptr == `CHANNEL_RUN_SELECT_OFS) begin
      rd_data = channel_run_select_q;
    end else begin
      rd_data = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // All bits, reserved ones included, are stored as written
  always @(posedge ref_clk) begin
    if (srst) begin
      modulator_config_q <= `MODULATOR_CONFIG_RST;
      audio_input_config_q <= `AUDIO_INPUT_CONFIG_RST;
      channel_run_select_q <= `CHANNEL_RUN_SELECT_RST;
    end else if (wr_stb) begin
      if (reg_ptr == `MODULATOR_CONFIG_OFS) begin
        modulator_config_q <= wr_data;
      end else if (reg_ptr == `AUDIO_INPUT_CONFIG_OFS) begin
        audio_input_config_q <= wr_data;
      end else if (reg_ptr == `CHANNEL_RUN_SELECT_OFS) begin
        channel_run_select_q <= wr_data;
      end
    end
  end

  // Reserved frequency codes give zero so the modulator stays idle
  function [5:0] freq_mult;
    input [2:0] code;
    begin
      case (code)
        3'h0: freq_mult = 6'h08;
        3'h1: freq_mult = 6'h0a;
        3'h5: freq_mult = 6'h26;
        3'h6: freq_mult = 6'h2c;
        3'h7: freq_mult = 6'h30;
        default: freq_mult = 6'h00;
      endcase
    end
  endfunction

  function [5:0] phase_deg;
    input [1:0] code;
    begin
      case (code)
        2'h0: phase_deg = 6'h00;
        2'h1: phase_deg = 6'h1e;
        2'h2: phase_deg = 6'h2d;
        default: phase_deg = 6'h3c;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Audio pins
  // ----------------------------------------------------------------------
  reg bck_s1, bck_s2, bck_s3, fs_s1, fs_s2, sd_s1, sd_s2;
  reg fs_prev_q, pend_q, active_q;
  reg [5:0] bit_q;
  reg [2:0] slot_q;
  reg [31:0] sh_q;
  reg [SAMPLE_W-1:0] slot_mem [0:`SLOT_COUNT-1];
  wire [2:0] fmt = audio_input_config_q[`AIN_FMT_HI:`AIN_FMT_LO];
  wire slot16 = audio_input_config_q[`AIN_SLOT16_BIT];
  wire group_hi = audio_input_config_q[`AIN_GROUP_BIT];
  wire swap = audio_input_config_q[`AIN_SWAP_BIT];
  wire bck_rise = bck_s2 & ~bck_s3;
  wire fs_edge = (fmt == `FMT_I2S) ? (fs_prev_q & ~fs_s2) : (~fs_prev_q & fs_s2);
  wire late_start = (fmt == `FMT_I2S) || (fmt == `FMT_DSP);
  wire [5:0] slot_last = slot16 ? 6'h0f : 6'h1f;
  wire [31:0] sh_next = {sh_q[30:0], sd_s2};
  reg [SAMPLE_W-1:0] word;

  // Right-justified data sits at the slot's end; the rest are MSB-first
  always @* begin
    word = slot16 ? {sh_next[15:0], 8'h00} : sh_next[31:8];
    case (fmt)
      `FMT_RJ24: word = sh_next[23:0];
      `FMT_RJ20: word = {sh_next[19:0], 4'h0};
      `FMT_RJ18: word = {sh_next[17:0], 6'h00};
      `FMT_RJ16: word = {sh_next[15:0], 8'h00};
      default: word = word;
    endcase
  end

  always @(posedge ref_clk) begin
    bck_s1 <= bit_clk_in;
    bck_s2 <= bck_s1;
    bck_s3 <= bck_s2;
    fs_s1 <= frame_sync_in;
    fs_s2 <= fs_s1;
    sd_s1 <= serial_data_in;
    sd_s2 <= sd_s1;
  end

  // ----------------------------------------------------------------------
  // Slot capture
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      fs_prev_q <= 1'b0;
      pend_q <= 1'b0;
      active_q <= 1'b0;
      bit_q <= 6'h00;
      slot_q <= 3'h0;
      sh_q <= 32'h00000000;
    end else if (bck_rise) begin
      fs_prev_q <= fs_s2;
      pend_q <= 1'b0;
      sh_q <= sh_next;
      if ((fs_edge && !late_start) || pend_q) begin
        active_q <= 1'b1;
        bit_q <= 6'h01;
        slot_q <= 3'h0;
        sh_q <= {31'h00000000, sd_s2};
      end else begin
        // In delayed formats the edge bit still carries the last slot's final bit
        if (fs_edge) begin
          pend_q <= 1'b1;
        end
        if (active_q) begin
          bit_q <= bit_q + 6'h01;
          if (bit_q == slot_last) begin
            slot_mem[slot_q] <= word;
            bit_q <= 6'h00;
            slot_q <= slot_q + 3'h1;
            if (slot_q == 3'h7) begin
              active_q <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel samples refreshed at every frame start; the other outputs every cycle
  // ----------------------------------------------------------------------
  // One update per frame, once the previous frame's last slot is stored
  wire frame_done = bck_rise && ((fs_edge && !late_start) || pend_q);
  wire [2:0] base = {group_hi, 2'h0};
  wire [2:0] pa = {group_hi, swap, 1'b0};
  wire [2:0] pb = {group_hi, ~swap, 1'b0};
  wire [1:0] rs1 = channel_run_select_q[7:6];
  wire [1:0] rs2 = channel_run_select_q[5:4];
  wire [1:0] rs3 = channel_run_select_q[3:2];
  wire [1:0] rs4 = channel_run_select_q[1:0];

  always @(posedge ref_clk) begin
    if (srst) begin
      ch1_sample <= {SAMPLE_W{1'b0}};
      ch2_sample <= {SAMPLE_W{1'b0}};
      ch3_sample <= {SAMPLE_W{1'b0}};
      ch4_sample <= {SAMPLE_W{1'b0}};
      sample_valid <= 1'b0;
      ch_output_float <= 4'hf;
      ch_diag_run <= 4'h0;
      switch_mult <= 6'h00;
      modulator_oversample_select <= 1'b0;
      phase_offset_deg <= 6'h00;
      incoming_rate_select <= 2'h0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      switch_mult <= freq_mult(modulator_config_q[`MOD_FREQ_HI:`MOD_FREQ_LO]);
      modulator_oversample_select <= modulator_config_q[`MOD_OSR_BIT];
      phase_offset_deg <= phase_deg(modulator_config_q[`MOD_PHASE_HI:`MOD_PHASE_LO]);
      incoming_rate_select <= audio_input_config_q[`AIN_RATE_HI:`AIN_RATE_LO];
      ch_output_float <= {rs1 == `RUN_FLOAT, rs2 == `RUN_FLOAT,
                          rs3 == `RUN_FLOAT, rs4 == `RUN_FLOAT};
      ch_diag_run <= {rs1 == `RUN_DIAG, rs2 == `RUN_DIAG,
                      rs3 == `RUN_DIAG, rs4 == `RUN_DIAG};
      sample_valid <= frame_done && (base[2] == group_hi);
      if (frame_done) begin
        ch1_sample <= (rs1 == `RUN_PLAY) ? slot_mem[pa] : {SAMPLE_W{1'b0}};
        ch2_sample <= (rs2 == `RUN_PLAY) ? slot_mem[pa | 3'h1] : {SAMPLE_W{1'b0}};
        ch3_sample <= (rs3 == `RUN_PLAY) ? slot_mem[pb] : {SAMPLE_W{1'b0}};
        ch4_sample <= (rs4 == `RUN_PLAY) ? slot_mem[pb | 3'h1] : {SAMPLE_W{1'b0}};
      end
    end
  end

endmodule

//--- audio_port_modulator_config_props.sv
// Purpose: Port checks for the audio port and modulator config block.
// Assumes: Config registers are seen only through their derived outputs.
// Notes: Bound to every instance of the block.
module audio_port_modulator_config_props #(
  parameter SAMPLE_W = 24
) (
  input wire ref_clk,
  input wire srst,
  input wire sample_valid,
  input wire [SAMPLE_W-1:0] ch1_sample,
  input wire [3:0] ch_output_float,
  input wire [3:0] ch_diag_run,
  input wire [5:0] switch_mult,
  input wire modulator_oversample_select,
  input wire [5:0] phase_offset_deg,
  input wire [1:0] incoming_rate_select
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_rst_mod;
    $fell(srst) |=> switch_mult == 6'h2c && phase_offset_deg == 6'h2d
      && !modulator_oversample_select;
  endproperty
  a_rst_mod: assert property (p_rst_mod)
    else $error("modulator defaults wrong");
  property p_rst_ain;
    $fell(srst) |=> incoming_rate_select == 2'h0;
  endproperty
  a_rst_ain: assert property (p_rst_ain)
    else $error("input rate default wrong");
  property p_rst_run;
    $fell(srst) |=> ch_output_float == 4'hf ##0 ch_diag_run == 4'h0;
  endproperty
  a_rst_run: assert property (p_rst_run)
    else $error("run state default wrong");
  property p_mult_legal;
    switch_mult inside {6'h00, 6'h08, 6'h0a, 6'h26, 6'h2c, 6'h30};
  endproperty
  a_mult_legal: assert property (p_mult_legal)
    else $error("switch multiple illegal");
  property p_phase_legal;
    phase_offset_deg inside {6'h00, 6'h1e, 6'h2d, 6'h3c};
  endproperty
  a_phase_legal: assert property (p_phase_legal)
    else $error("phase offset illegal");
  property p_excl;
    (ch_output_float & ch_diag_run) == 4'h0;
  endproperty
  a_excl: assert property (p_excl)
    else $error("channel both floating and in diagnostics");
  property p_valid_pulse;
    sample_valid |=> !sample_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("sample valid longer than one cycle");
  property p_sample_hold;
    $changed(ch1_sample) |-> sample_valid;
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("sample changed without valid");
  c_valid: cover property (sample_valid);
  c_mult48: cover property (switch_mult == 6'h30);
  c_diag: cover property (ch_diag_run != 4'h0);
endmodule

bind audio_port_modulator_config audio_port_modulator_config_props #(
  .SAMPLE_W(SAMPLE_W)
) props_u (
  .ref_clk(ref_clk),
  .srst(srst),
  .sample_valid(sample_valid),
  .ch1_sample(ch1_sample),
  .ch_output_float(ch_output_float),
  .ch_diag_run(ch_diag_run),
  .switch_mult(switch_mult),
  .modulator_oversample_select(modulator_oversample_select),
  .phase_offset_deg(phase_offset_deg),
  .incoming_rate_select(incoming_rate_select)
);

//--- audio_host_model.sv
// Purpose: Host audio source driving serial frames of eight slots.
// Assumes: Slot value is {tag, slot number, 8'hc3}, MSB first.
// Notes: Bit clock stands still between bursts.
`include "amp_cfg_map.vh"

module audio_host_model (
  output logic bit_clk,
  output logic frame_sync,
  output logic sdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b1;
    sdata = 1'b0;
  end
  // Two lead-in bits play the tail of an earlier frame so the first
  // frame edge is seen by the edge detector
  task automatic send(input [2:0] fmt, input s16, input [7:0] tg, input int nf);
    int sb;
    int fb;
    int bi;
    int d;
    logic [31:0] v;
    sb = s16 ? 16 : 32;
    fb = 8 * sb;
    #1.3;
    for (int b = -2; b < nf * fb; b++) begin
      bi = (b + fb) % fb;
      d = (fmt == `FMT_I2S || fmt == `FMT_DSP) ? (bi + fb - 1) % fb : bi;
      v = {tg, 8'(d / sb), 8'hc3, 8'h00};
      if (b < 0) begin
        frame_sync = (fmt == `FMT_I2S);
        sdata = ~sdata;
      end else begin
        frame_sync = (fmt == `FMT_I2S) ? bi >= fb / 2 :
          (fmt == `FMT_DSP) ? bi == 0 : bi < fb / 2;
        sdata = v[31 - d % sb];
      end
      #80 bit_clk = 1'b1;
      #80 bit_clk = 1'b0;
    end
    sdata = ~sdata;
  endtask
endmodule

//--- audio_port_modulator_config_test.sv
// Purpose: Self-checking bench for the audio port and modulator config block.
// Assumes: Control port at its default device address.
// Notes: Run stays near 76k cycles; a ceiling cuts a hang short.
`include "amp_cfg_map.vh"

module audio_port_modulator_config_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [6:0] addr = `CTRL_DEV_ADDR;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic scl = 1'b1;
  logic m_sda = 1'b1;
  logic bclk, fs, sd, sda_oe_n, valid, osr, sda_o;
  int n_valid = 0;
  logic [23:0] ch1, ch2, ch3, ch4;
  logic [3:0] flt, dia;
  logic [5:0] mult, ph;
  logic [1:0] rate;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  // Open drain with pull-up
  wire sda = sda_oe_n ? m_sda : 1'b0;

  initial forever #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (valid === 1'b1) n_valid++;
  end

  audio_port_modulator_config dut_u (
    .ref_clk(ref_clk),
    .srst(srst),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_o),
    .sda_oe_n(sda_oe_n),
    .bit_clk_in(bclk),
    .frame_sync_in(fs),
    .serial_data_in(sd),
    .ch1_sample(ch1),
    .ch2_sample(ch2),
    .ch3_sample(ch3),
    .ch4_sample(ch4),
    .sample_valid(valid),
    .ch_output_float(flt),
    .ch_diag_run(dia),
    .switch_mult(mult),
    .modulator_oversample_select(osr),
    .phase_offset_deg(ph),
    .incoming_rate_select(rate)
  );
  audio_host_model host_u (
    .bit_clk(bclk),
    .frame_sync(fs),
    .sdata(sd)
  );
  // ----------------------------------------
  // Control port tasks
  // ----------------------------------------
  task automatic chk(input [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hp;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic bio(input b, output r);
    m_sda <= b;
    hp;
    scl <= 1'b1;
    hp;
    r = sda;
    scl <= 1'b0;
    hp;
  endtask
  task automatic xb(input [7:0] w, input ma, output [7:0] r, output ak);
    for (int i = 7; i >= 0; i--) bio(w[i], r[i]);
    bio(ma, ak);
  endtask
  task automatic sta;
    m_sda <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    m_sda <= 1'b0;
    hp;
    scl <= 1'b0;
    hp;
  endtask
  task automatic sto;
    m_sda <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    m_sda <= 1'b1;
    hp;
  endtask
  task automatic wr(input [7:0] a, d);
    logic [7:0] r;
    logic k0, k1, k2;
    sta;
    xb({addr, 1'b0}, 1'b1, r, k0);
    xb(a, 1'b1, r, k1);
    xb(d, 1'b1, r, k2);
    sto;
    chk({k0, k1, k2}, 3'h0);
  endtask
  task automatic rc(input [7:0] a, e);
    logic [7:0] r;
    logic k0, k1, k2;
    sta;
    xb({addr, 1'b0}, 1'b1, r, k0);
    xb(a, 1'b1, r, k1);
    sta;
    xb({addr, 1'b1}, 1'b1, r, k2);
    xb(8'hff, 1'b1, r, k0);
    sto;
    chk({k1, k2, r}, {2'h0, e});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rc(8'h02, 8'h62);
    rc(8'h03, 8'h04);
    rc(8'h04, 8'h55);
    chk({mult, ph, osr, rate}, {6'h2c, 6'h2d, 1'b0, 2'h0});
    chk(flt, 4'hf);
    $display("test reset done");
  endtask
  task automatic t_mod;
    logic [5:0] mtab [8] = '{6'h08, 6'h0a, 6'h00, 6'h00, 6'h00, 6'h26, 6'h2c, 6'h30};
    logic [5:0] ptab [4] = '{6'h00, 6'h1e, 6'h2d, 6'h3c};
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[2:0], i[0], i[1], i[1:0]};
      wr(8'h02, v);
      rc(8'h02, v);
      chk({mult, osr, ph}, {mtab[i], v[2], ptab[v[1:0]]});
    end
    wr(8'h02, 8'h62);
    $display("test modulator done");
  endtask
  task automatic t_run;
    logic [7:0] r;
    logic k;
    wr(8'h04, 8'h1b);
    rc(8'h04, 8'h1b);
    chk({flt, dia}, 8'h41);
    sta;
    xb({addr ^ 7'h01, 1'b0}, 1'b1, r, k);
    sto;
    chk(k, 1'b1);
    chk(sda_o, 1'b0);
    rc(8'h05, 8'h00);
    wr(8'h04, 8'h00);
    chk({flt, dia}, 8'h00);
    $display("test run state done");
  endtask
  task automatic aud(input [7:0] cfg, tg);
    logic [23:0] got [4];
    int slot;
    int n0;
    wr(8'h03, cfg);
    chk(rate, cfg[7:6]);
    n0 = n_valid;
    host_u.send(cfg[2:0], cfg[4], tg, 2);
    chk(n_valid - n0, 2);
    got = '{ch1, ch2, ch3, ch4};
    for (int c = 0; c < 4; c++) begin
      slot = 4 * cfg[5] + 2 * ((c < 2) ? cfg[3] : !cfg[3]) + c % 2;
      chk(got[c], {tg, slot[7:0], cfg[4] ? 8'h00 : 8'hc3});
    end
    rc(8'h03, cfg);
    $display("test audio %h done", cfg);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      stop_test;
    end
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_mod;
    t_run;
    aud(8'h04, 8'h11);
    aud(8'hbe, 8'h22);
    aud(8'h65, 8'h33);
    aud(8'h13, 8'h44);
    stop_test;
  end
endmodule
